// ---- core/eeh_pkg.sv ----
// Purpose: shared constants and carriers for the two-wire eeprom host controller
// Assumes: one eeprom target, 17-bit word address, 256-byte pages
// Notes: bus timing counts derive from the system clock rate
package eeh_pkg;
  localparam int unsigned SYS_CLK_MHZ = 250;
  localparam int unsigned SCL_HALF_NS = 1300;   // longest low time at the lowest supply
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned PROG_TIME_MS = 5;     // internal_program_time
  localparam int unsigned PROG_TIME_CYC = PROG_TIME_MS * SYS_CLK_MHZ * 1000;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned RECOVER_CLOCKS = 9;
  localparam logic [3:0] DEV_TYPE = 4'ha;       // one-zero-one-zero type code
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam int unsigned PAGE_MSB_POS = 16;

  // operation requested by the user side
  typedef enum logic [2:0] {
    EEH_OP_WRITE = 3'h0,    // byte or page write
    EEH_OP_CUR_RD = 3'h1,   // current-address read
    EEH_OP_RAND_RD = 3'h2,  // random read, dummy write first
    EEH_OP_POLL = 3'h3,     // acknowledge poll
    EEH_OP_RECOVER = 3'h4   // protocol reset sequence
  } eeh_op_t;

  typedef struct packed {
    eeh_op_t op;
    logic [1:0] sel;              // select_pin_high, select_pin_low levels
    logic [ADDR_W-1:0] addr;
    logic [8:0] count;            // bytes to move, 1..256
  } eeh_cmd_t;

  typedef struct packed {
    logic scl_o;
    logic sda_o;
    logic sda_oe;
  } eeh_pins_t;
endpackage : eeh_pkg

// ---- core/eeh_host.sv ----
// Purpose: two-wire bus controller driving a serial eeprom through its pins
// Assumes: open-drain lines, external pull-ups, target never stretches the clock
// Notes: clock is generated here by a divider; sda leaves as an enable-style signal, scl is pushed
`timescale 1ns/1ns
`default_nettype none
module eeh_host #(
  parameter int unsigned PROG_CYC = eeh_pkg::PROG_TIME_CYC,
  parameter int unsigned HALF_CYC = eeh_pkg::SCL_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire eeh_pkg::eeh_cmd_t cmd,
  output logic cmd_ready,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_err,
  output logic scl_o,
  output logic sda_o,
  output logic sda_oe,
  input wire logic sda_i
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_START = 9'h002, S_BYTE = 9'h004, S_ACK = 9'h008,
    S_RBYTE = 9'h010, S_MACK = 9'h020, S_STOP = 9'h040, S_PROG = 9'h080,
    S_RECOV = 9'h100
  } eeh_st_t;
  // phase within a byte sequence: device word, word msb, word lsb, data
  typedef enum logic [3:0] {
    P_DEV = 4'h1, P_AHI = 4'h2, P_ALO = 4'h4, P_DATA = 4'h8
  } eeh_ph_t;

  eeh_st_t st, next_st;
  eeh_ph_t ph, next_ph;
  eeh_pkg::eeh_cmd_t cur, next_cur;
  logic [31:0] tick, next_tick, prog, next_prog;
  logic [1:0] qtr, next_qtr;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, rdd_r, next_rdd;
  logic [8:0] left, next_left;
  logic restart, next_restart, sda_m, sda_s, q_end;
  logic scl_r, next_scl, sda_r, next_sda, oe_r, next_oe, rdy_r, next_rdy;
  logic take_r, next_take, rdv_r, next_rdv, done_r, next_done, nack_r, next_nack;

  // the data line arrives from outside the clock domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_m <= 1'h1;
      sda_s <= 1'h1;
    end else begin
      sda_m <= sda_i;
      sda_s <= sda_m;
    end
  end

  // each bit is four quarter phases: low-change, low-hold, high-sample, high-hold
  assign q_end = (tick == 32'(HALF_CYC / 2));

  // main sequencer
  always_comb begin
    next_st = st;
    next_ph = ph;
    next_cur = cur;
    next_tick = q_end ? 32'h0 : tick + 32'h1;
    next_qtr = q_end ? qtr + 2'h1 : qtr;
    next_bitn = bitn;
    next_shreg = shreg;
    next_left = left;
    next_restart = restart;
    next_prog = (prog != 32'h0) ? prog - 32'h1 : 32'h0;
    next_scl = scl_r;
    next_sda = sda_r;
    next_take = 1'h0;
    next_rdv = 1'h0;
    next_rdd = rdd_r;
    next_done = 1'h0;
    next_nack = nack_r;
    case (st)
      S_IDLE: begin
        next_scl = 1'h1;
        next_sda = 1'h1;
        next_tick = 32'h0;
        next_qtr = 2'h0;
        if (cmd_valid) begin
          next_cur = cmd;
          next_nack = 1'h0;
          next_left = cmd.count;
          next_restart = 1'h0;
          next_bitn = 4'h0;
          next_st = (cmd.op == eeh_pkg::EEH_OP_RECOVER) ? S_RECOV : S_START;
        end
      end
      S_START: begin
        // sda falls while scl high, then scl falls; also serves as repeated start
        if (q_end) begin
          case (qtr)
            2'h0: begin next_sda = 1'h1; next_scl = 1'h0; end
            2'h1: next_scl = 1'h1;
            2'h2: next_sda = 1'h0;
            default: begin
              next_scl = 1'h0;
              next_ph = P_DEV;
              // device word: type, selects, page msb, direction
              next_shreg = {eeh_pkg::DEV_TYPE, cur.sel,
                cur.addr[eeh_pkg::PAGE_MSB_POS],
                (cur.op == eeh_pkg::EEH_OP_CUR_RD || restart) ?
                eeh_pkg::RW_READ : eeh_pkg::RW_WRITE};
              next_bitn = 4'h0;
              // recovery ends with start then stop, leaving the target's counter alone
              next_st = (cur.op == eeh_pkg::EEH_OP_RECOVER) ? S_STOP : S_BYTE;
            end
          endcase
        end
      end
      S_BYTE: begin
        if (q_end) begin
          case (qtr)
            2'h0: next_sda = shreg[7];
            2'h1: next_scl = 1'h1;
            2'h2: ;
            default: begin
              next_scl = 1'h0;
              next_shreg = {shreg[6:0], 1'h0};
              next_bitn = bitn + 4'h1;
              if (bitn == 4'h7) begin
                next_st = S_ACK;
              end
            end
          endcase
        end
      end
      S_ACK: begin
        if (q_end) begin
          case (qtr)
            2'h0: next_sda = 1'h1;                             // release for target
            2'h1: next_scl = 1'h1;
            2'h2: next_nack = sda_s && (cur.op != eeh_pkg::EEH_OP_POLL);
            default: begin
              next_scl = 1'h0;
              next_bitn = 4'h0;
              if (nack_r) begin
                next_st = S_STOP;
              end else if (ph == P_DEV && cur.op == eeh_pkg::EEH_OP_POLL) begin
                next_st = sda_s ? S_START : S_STOP;
              end else if (ph == P_DEV && (cur.op == eeh_pkg::EEH_OP_CUR_RD || restart)) begin
                next_st = S_RBYTE;
              end else if (ph == P_DEV) begin
                next_ph = P_AHI;
                next_shreg = cur.addr[15:8];
                next_st = S_BYTE;
              end else if (ph == P_AHI) begin
                next_ph = P_ALO;
                next_shreg = cur.addr[7:0];
                next_st = S_BYTE;
              end else if (ph == P_ALO && cur.op == eeh_pkg::EEH_OP_RAND_RD) begin
                next_restart = 1'h1;
                next_st = S_START;
              end else if (left != 9'h0) begin
                // byte or page write: next data byte
                next_ph = P_DATA;
                next_shreg = wr_data;
                next_take = 1'h1;
                next_left = left - 9'h1;
                next_st = S_BYTE;
              end else begin
                next_st = S_STOP;
              end
            end
          endcase
        end
      end
      S_RBYTE: begin
        if (q_end) begin
          case (qtr)
            2'h0: next_sda = 1'h1;
            2'h1: next_scl = 1'h1;
            2'h2: next_shreg = {shreg[6:0], sda_s};
            default: begin
              next_scl = 1'h0;
              next_bitn = bitn + 4'h1;
              if (bitn == 4'h7) begin
                next_rdd = shreg;
                next_rdv = 1'h1;
                next_left = (left > 9'h1) ? left - 9'h1 : 9'h0;
                next_st = S_MACK;
              end
            end
          endcase
        end
      end
      S_MACK: begin
        // acknowledge keeps a sequential read going; last byte gets none
        if (q_end) begin
          case (qtr)
            2'h0: next_sda = (left == 9'h0);
            2'h1: next_scl = 1'h1;
            2'h2: ;
            default: begin
              next_scl = 1'h0;
              next_bitn = 4'h0;
              next_st = (left == 9'h0) ? S_STOP : S_RBYTE;
            end
          endcase
        end
      end
      S_STOP: begin
        if (q_end) begin
          case (qtr)
            2'h0: next_sda = 1'h0;
            2'h1: next_scl = 1'h1;
            2'h2: next_sda = 1'h1;
            default: begin
              next_done = 1'h1;
              if (cur.op == eeh_pkg::EEH_OP_WRITE && !nack_r) begin
                next_prog = 32'(PROG_CYC);
                next_st = S_PROG;
              end else begin
                next_st = S_IDLE;
              end
            end
          endcase
        end
      end
      S_PROG: begin
        // target is deaf while programming; hold the bus idle
        next_scl = 1'h1;
        next_sda = 1'h1;
        if (prog == 32'h0) begin
          next_st = S_IDLE;
        end
      end
      S_RECOV: begin
        if (q_end) begin
          case (qtr)
            2'h0: next_sda = 1'h1;
            2'h1: next_scl = 1'h1;
            2'h2: begin
              next_bitn = bitn + 4'h1;
              if (sda_s || bitn == 4'(eeh_pkg::RECOVER_CLOCKS - 1)) begin
                next_qtr = 2'h1;
                next_st = S_START;
              end
            end
            default: next_scl = 1'h0;
          endcase
        end
      end
      default: next_st = S_IDLE;
    endcase
    next_rdy = (next_st == S_IDLE);
    next_oe = ~next_sda;                                       // pull low only for a zero
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= S_IDLE;
      ph <= P_DEV;
      cur <= '0;
      tick <= 32'h0;
      qtr <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h0;
      left <= 9'h0;
      restart <= 1'h0;
      prog <= 32'h0;
      scl_r <= 1'h1;
      sda_r <= 1'h1;
      oe_r <= 1'h0;
      rdy_r <= 1'h1;
      take_r <= 1'h0;
      rdv_r <= 1'h0;
      rdd_r <= 8'h0;
      done_r <= 1'h0;
      nack_r <= 1'h0;
    end else begin
      st <= next_st;
      ph <= next_ph;
      cur <= next_cur;
      tick <= next_tick;
      qtr <= next_qtr;
      bitn <= next_bitn;
      shreg <= next_shreg;
      left <= next_left;
      restart <= next_restart;
      prog <= next_prog;
      scl_r <= next_scl;
      sda_r <= next_sda;
      oe_r <= next_oe;
      rdy_r <= next_rdy;
      take_r <= next_take;
      rdv_r <= next_rdv;
      rdd_r <= next_rdd;
      done_r <= next_done;
      nack_r <= next_nack;
    end
  end

  // open-drain: enable asserted only to pull low; scl is pushed by this end
  assign scl_o = scl_r;
  assign sda_o = 1'h0;
  assign sda_oe = oe_r;
  assign cmd_ready = rdy_r;
  assign wr_take = take_r;
  assign rd_data = rdd_r;
  assign rd_valid = rdv_r;
  assign done = done_r;
  assign nack_err = nack_r;
endmodule : eeh_host
`default_nettype wire

// ---- tb/eeh_host_monitor.sv ----
// Purpose: pin protocol checks for the eeprom host
// Assumes: one clock domain, sim divider set to 20, giving 22 cycles per half period
// Notes: bound onto every eeh_host instance
`timescale 1ns/1ns
`default_nettype none
module eeh_host_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire eeh_pkg::eeh_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic wr_take,
  input wire logic rd_valid,
  input wire logic done,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // bus quiet and released whenever a command may be taken
  a_idle_lines: assert property (cmd_ready |-> scl_o && !sda_oe) else $error("idle bus");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready");
  a_start_first: assert property (cmd_valid && cmd_ready && cmd.op != eeh_pkg::EEH_OP_RECOVER
    |=> ##[0:60] ($rose(sda_oe) && scl_o)) else $error("no start");
  // data never moves on a clock edge, so setup and hold stay clean
  a_data_setup: assert property ($changed(scl_o) |-> $stable(sda_oe)) else $error("sda");
  a_open_drain: assert property (sda_o == 1'h0) else $error("sda driven high");
  a_scl_high: assert property ($rose(scl_o) |-> scl_o [*8]) else $error("scl high short");
  a_scl_low: assert property ($fell(scl_o) |-> !scl_o [*8]) else $error("scl low short");
  a_done_stop: assert property (done |-> scl_o && !sda_oe ##1 !done) else $error("done");
  a_take_pulse: assert property (wr_take |=> !wr_take) else $error("take pulse");
  a_read_pulse: assert property (rd_valid |=> !rd_valid) else $error("read pulse");
endmodule : eeh_host_monitor
bind eeh_host eeh_host_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd(cmd), .cmd_ready(cmd_ready), .wr_take(wr_take), .rd_valid(rd_valid), .done(done),
  .scl_o(scl_o), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ---- tb/eeh_eeprom_model.sv ----
// Purpose: behavioural two-wire eeprom target
// Assumes: bus sampled by the system clock, no clock stretching
// Notes: bytes land at once; the program wait only blocks the bus
`timescale 1ns/1ns
`default_nettype none
module eeh_eeprom_model #(
  parameter logic [1:0] SEL = 2'h0,
  parameter int PROG = 2000
) (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic wp,
  output logic pull
);
  logic [7:0] mem [0:131071];
  logic [16:0] ptr;
  logic [7:0] sh, out;
  logic ps, pd, wrote;
  int n, st, busy;
  // known pattern so reads are predictable; starts in standby
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'(i) ^ 8'h3c;
    pull = 0; ps = 1; pd = 1; st = 0; n = 0; busy = 0; wrote = 0; ptr = '0;
  end
  // edge decode; everything is deaf while programming
  always @(posedge sys_clk) begin
    ps <= scl;
    pd <= sda;
    if (busy > 0) begin
      busy <= busy - 1;
    end else if (ps && scl && pd && !sda) begin
      st <= 1;
      n <= 0;
    end else if (ps && scl && !pd && sda) begin
      st <= 0;
      if (wrote) busy <= PROG;
      wrote <= 0;
    end else if (!ps && scl && st != 0) begin
      sh <= {sh[6:0], sda};
      n <= n + 1;
      if (n == 8 && st == 5 && sda) st <= 0;
    end else if (ps && !scl && st != 0) begin
      if (n == 8 && st == 5) pull <= 0;
      else if (n == 8) begin
        pull <= 1;
        case (st)
          1: if (sh[7:4] == 4'ha && sh[3:2] == SEL) begin
            st <= sh[0] ? 5 : 2;
            if (!sh[0]) ptr[16] <= sh[1];
          end else begin
            st <= 0;
            pull <= 0;
          end
          2: begin ptr[15:8] <= sh; st <= 3; end
          3: begin ptr[7:0] <= sh; st <= 4; end
          default: begin
            if (!wp) mem[ptr] <= sh;
            ptr[7:0] <= ptr[7:0] + 8'h01;
            wrote <= 1;
          end
        endcase
      end else if (n == 9) begin
        n <= 0;
        pull <= 0;
        if (st == 5) begin
          out <= mem[ptr];
          pull <= ~mem[ptr][7];
          ptr <= ptr + 17'h1;
        end
      end else if (st == 5) pull <= ~out[7 - n];
    end
  end
endmodule : eeh_eeprom_model
`default_nettype wire

// ---- tb/eeh_host_tb.sv ----
// Purpose: self-checking bench for the eeprom host
// Assumes: short divider and program wait set through parameters
// Notes: target slower than the host wait, so polling must retry
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module eeh_host_tb;
  logic sys_clk, rst_b, cmd_valid, wp, tk, pull, sda;
  logic cmd_ready, wr_take, rd_valid, done, nack_err, scl_o, sda_o, sda_oe;
  eeh_pkg::eeh_cmd_t cmd;
  logic [7:0] rd_data, wr_data;
  logic [7:0] wq [0:3] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4};
  logic [7:0] rq [$];
  int wi, bad_count, total_checks;
  assign sda = (sda_oe ? sda_o : 1'b1) & !pull; // pull-up wire
  assign wr_data = wq[wi];
  eeh_host #(.PROG_CYC(200), .HALF_CYC(20)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .wr_data(wr_data),
    .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .nack_err(nack_err), .scl_o(scl_o), .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda));
  eeh_eeprom_model u_mem (.sys_clk(sys_clk), .scl(scl_o), .sda(sda), .wp(wp), .pull(pull));
  // clock
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  // collect read bytes, advance write data one cycle after each take
  always @(posedge sys_clk) begin
    #1;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (tk) wi++;
    tk = (wr_take === 1'b1);
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // one command, waiting for ready first and then for done
  task automatic run(input eeh_pkg::eeh_op_t op, input logic [1:0] s, input logic [16:0] a,
                     input logic [8:0] n);
    int t;
    t = 0;
    rq.delete();
    while (cmd_ready !== 1'b1 && t < 5000) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    cmd = '{op, s, a, n};
    cmd_valid = 1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 0;
    while (done !== 1'b1 && t < 20000) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    // a command that never finishes is a failure, not a silent fall-through
    if (t >= 20000) begin
      bad_count++;
      end_of_test();
    end
  endtask : run
  task automatic t_page_write();
    run(eeh_pkg::EEH_OP_WRITE, 2'h0, 17'h102fe, 9'd3);
    `CHK(nack_err, 1'b0)
    `CHK(u_mem.mem[17'h102fe], 8'ha1)
    `CHK(u_mem.mem[17'h102ff], 8'ha2)
    `CHK(u_mem.mem[17'h10200], 8'ha3)
    `CHK(u_mem.mem[17'h00200], 8'h00 ^ 8'h3c)
    run(eeh_pkg::EEH_OP_POLL, 2'h0, 17'h0, 9'd0);
    `CHK(nack_err, 1'b0)
    `CHK(u_mem.busy, 0)
  endtask : t_page_write
  task automatic t_reads();
    run(eeh_pkg::EEH_OP_RAND_RD, 2'h0, 17'h102fe, 9'd3);
    `CHK(rq[0], 8'ha1)
    `CHK(rq[1], 8'ha2)
    `CHK(rq[2], 8'h3c)
    run(eeh_pkg::EEH_OP_CUR_RD, 2'h0, 17'h0, 9'd1);
    `CHK(rq[0], 8'h3d)
    run(eeh_pkg::EEH_OP_RAND_RD, 2'h0, 17'h1ffff, 9'd2);
    `CHK(rq[0], 8'hc3)
    `CHK(rq[1], 8'h3c)
  endtask : t_reads
  task automatic t_protect();
    wp = 1;
    run(eeh_pkg::EEH_OP_WRITE, 2'h0, 17'h00010, 9'd1);
    run(eeh_pkg::EEH_OP_POLL, 2'h0, 17'h0, 9'd0);
    wp = 0;
    run(eeh_pkg::EEH_OP_RAND_RD, 2'h0, 17'h00010, 9'd1);
    `CHK(rq[0], 8'h2c)
  endtask : t_protect
  task automatic t_sel_recover();
    run(eeh_pkg::EEH_OP_WRITE, 2'h1, 17'h0, 9'd0);
    `CHK(nack_err, 1'b1)
    run(eeh_pkg::EEH_OP_RECOVER, 2'h0, 17'h0, 9'd0);
    run(eeh_pkg::EEH_OP_CUR_RD, 2'h0, 17'h0, 9'd1);
    `CHK(nack_err, 1'b0)
    `CHK(rq[0], 8'h2d)
  endtask : t_sel_recover
  // hang guard, well beyond the expected run
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_b = 0; cmd_valid = 0; cmd = '0; wp = 0; tk = 0; wi = 0;
    bad_count = 0; total_checks = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_b = 1;
    t_page_write();
    t_reads();
    t_protect();
    t_sel_recover();
    end_of_test();
  end
endmodule : eeh_host_tb
`default_nettype wire
